// ---- bscu_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module bscu_unit
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              op_valid,
    input  wire bscu_pkg::bscu_op_t op_code,
    input  wire logic [15:0]       op_pc,
    input  wire logic [7:0]        src_a,
    input  wire logic [7:0]        src_b,
    input  wire logic [7:0]        imm_value,
    input  wire logic [2:0]        bit_index,
    input  wire logic [6:0]        branch_offset,
    input  wire logic [15:0]       pointer_z,
    input  wire logic [7:0]        io_read_data,
    input  wire logic              next_is_two_word,
    input  wire logic [15:0]       stack_pop_data,
    input  wire logic [7:0]        status_flags_in,
    output logic                   op_ready,
    output logic                   busy,
    output logic [15:0]            pc_out,
    output logic                   pc_load,
    output logic [7:0]             status_flags_register,
    output logic                   flags_write,
    output logic [15:0]            push_data,
    output logic                   push_strobe,
    output logic                   pop_strobe,
    output logic [2:0]             cycle_cost
);
    typedef enum logic [1:0] {BSCU_IDLE, BSCU_WAIT} bscu_state_t;

    bscu_state_t state;
    bscu_state_t next_state;
    logic [2:0]  wait_count;
    logic [2:0]  next_wait_count;
    logic [15:0] next_pc_out;
    logic        next_pc_load;
    logic [7:0]  next_flags;
    logic        next_flags_write;
    logic [15:0] next_push_data;
    logic        next_push_strobe;
    logic        next_pop_strobe;
    logic [2:0]  next_cycle_cost;
    logic [5:0]  cmp_flags;
    logic        cmp_borrow;
    logic        cmp_chain;
    logic [7:0]  cmp_rhs;
    logic        take;
    logic        skip;
    logic        io_bit;
    logic        reg_bit;
    logic [15:0] target;
    logic [15:0] fall;

    // signed word displacement plus one
    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [6:0] k);
        rel_target = pc + {{9{k[6]}}, k} + 16'h0001;
    endfunction

    // skip distance: over a one-word or a two-word instruction
    function automatic logic [15:0] skip_target(input logic [15:0] pc, input logic two);
        skip_target = two ? pc + 16'h0003 : pc + 16'h0002;
    endfunction

    // compare operands; immediate compare uses the constant in place of a register
    always_comb
    begin
        cmp_rhs    = (op_code == bscu_pkg::BSCU_IMMEDIATE_COMPARE) ? imm_value : src_b;
        cmp_chain  = (op_code == bscu_pkg::BSCU_CARRY_COMPARE);
        cmp_borrow = cmp_chain & status_flags_in[bscu_pkg::FLAG_C];
    end

    bscu_compare u_compare
    (
        .lhs        (src_a),
        .rhs        (cmp_rhs),
        .borrow_in  (cmp_borrow),
        .chain_zero (cmp_chain),
        .old_zero   (status_flags_in[bscu_pkg::FLAG_Z]),
        .flags_out  (cmp_flags)
    );

    // bit selections; the io value arrives in the core clock domain from the io read path
    always_comb
    begin
        reg_bit = src_a[bit_index];
        io_bit  = io_read_data[bit_index];
        target  = rel_target(op_pc, branch_offset);
        fall    = op_pc + 16'h0001;
    end

    // one-cycle operations finish at once; multi-cycle ones hold busy until count ends
    always_comb
    begin
        next_state       = state;
        next_wait_count  = wait_count;
        next_pc_out      = pc_out;
        next_pc_load     = 1'b0;
        next_flags       = status_flags_register;
        next_flags_write = 1'b0;
        next_push_data   = push_data;
        next_push_strobe = 1'b0;
        next_pop_strobe  = 1'b0;
        next_cycle_cost  = cycle_cost;
        take             = 1'b0;
        skip             = 1'b0;
        if (state == BSCU_WAIT)
        begin
            if (wait_count <= 3'h1)
                next_state = BSCU_IDLE;
            next_wait_count = wait_count - 3'h1;
        end
        else if (op_valid)
        begin
            unique case (op_code)
                bscu_pkg::BSCU_INDIRECT_CALL:
                begin
                    next_push_data   = fall;
                    next_push_strobe = 1'b1;
                    next_pc_out      = pointer_z;
                    next_pc_load     = 1'b1;
                    next_cycle_cost  = bscu_pkg::CYC_CALL;
                end
                bscu_pkg::BSCU_SUBROUTINE_EXIT, bscu_pkg::BSCU_INTERRUPT_EXIT:
                begin
                    next_pop_strobe = 1'b1;
                    next_pc_out     = stack_pop_data;
                    next_pc_load    = 1'b1;
                    next_cycle_cost = bscu_pkg::CYC_RETURN;
                    if (op_code == bscu_pkg::BSCU_INTERRUPT_EXIT)
                    begin
                        next_flags = status_flags_in;
                        next_flags[bscu_pkg::FLAG_I] = 1'b1;
                        next_flags_write = 1'b1;
                    end
                end
                bscu_pkg::BSCU_REGISTER_COMPARE, bscu_pkg::BSCU_CARRY_COMPARE,
                bscu_pkg::BSCU_IMMEDIATE_COMPARE:
                begin
                    next_flags = {status_flags_in[7:6], cmp_flags};
                    next_flags_write = 1'b1;
                    next_cycle_cost  = bscu_pkg::CYC_BASE;
                end
                bscu_pkg::BSCU_EQUAL_SKIP:       skip = (src_a == src_b);
                bscu_pkg::BSCU_SKIP_REG_BIT_CLEAR: skip = ~reg_bit;
                bscu_pkg::BSCU_SKIP_REG_BIT_SET:   skip = reg_bit;
                bscu_pkg::BSCU_SKIP_IO_BIT_CLEAR:  skip = ~io_bit;
                bscu_pkg::BSCU_SKIP_IO_BIT_SET:    skip = io_bit;
                bscu_pkg::BSCU_FLAG_SET_BRANCH:    take = status_flags_in[bit_index];
                bscu_pkg::BSCU_FLAG_CLEAR_BRANCH:  take = ~status_flags_in[bit_index];
                bscu_pkg::BSCU_EQUAL_BRANCH:   take = status_flags_in[bscu_pkg::FLAG_Z];
                bscu_pkg::BSCU_UNEQUAL_BRANCH: take = ~status_flags_in[bscu_pkg::FLAG_Z];
                bscu_pkg::BSCU_CARRY_SET_BRANCH, bscu_pkg::BSCU_LOWER_BRANCH:
                    take = status_flags_in[bscu_pkg::FLAG_C];
                bscu_pkg::BSCU_CARRY_CLEAR_BRANCH, bscu_pkg::BSCU_SAME_HIGHER_BRANCH:
                    take = ~status_flags_in[bscu_pkg::FLAG_C];
                bscu_pkg::BSCU_MINUS_BRANCH: take = status_flags_in[bscu_pkg::FLAG_N];
                bscu_pkg::BSCU_PLUS_BRANCH:  take = ~status_flags_in[bscu_pkg::FLAG_N];
                bscu_pkg::BSCU_SIGNED_GE_BRANCH:
                    take = ~(status_flags_in[bscu_pkg::FLAG_N]
                             ^ status_flags_in[bscu_pkg::FLAG_V]);
                bscu_pkg::BSCU_SIGNED_LESS_BRANCH:
                    take = status_flags_in[bscu_pkg::FLAG_N]
                           ^ status_flags_in[bscu_pkg::FLAG_V];
                bscu_pkg::BSCU_HALF_CARRY_SET_BRANCH:
                    take = status_flags_in[bscu_pkg::FLAG_H];
                bscu_pkg::BSCU_HALF_CARRY_CLEAR_BRANCH:
                    take = ~status_flags_in[bscu_pkg::FLAG_H];
                bscu_pkg::BSCU_XFER_FLAG_SET_BRANCH:
                    take = status_flags_in[bscu_pkg::FLAG_T];
                bscu_pkg::BSCU_XFER_FLAG_CLEAR_BRANCH:
                    take = ~status_flags_in[bscu_pkg::FLAG_T];
                bscu_pkg::BSCU_OVERFLOW_SET_BRANCH:
                    take = status_flags_in[bscu_pkg::FLAG_V];
                default:
                    next_cycle_cost = bscu_pkg::CYC_BASE;
            endcase
            if (op_code >= bscu_pkg::BSCU_EQUAL_SKIP && op_code <= bscu_pkg::BSCU_SKIP_IO_BIT_SET
                && op_code != bscu_pkg::BSCU_REGISTER_COMPARE
                && op_code != bscu_pkg::BSCU_CARRY_COMPARE
                && op_code != bscu_pkg::BSCU_IMMEDIATE_COMPARE)
            begin
                // skips: pc always reloaded so the fetch unit sees the true next address
                next_pc_load    = 1'b1;
                next_pc_out     = skip ? skip_target(op_pc, next_is_two_word) : fall;
                next_cycle_cost = !skip ? bscu_pkg::CYC_BASE
                                : (next_is_two_word ? bscu_pkg::CYC_SKIP2
                                                    : bscu_pkg::CYC_SKIP1);
            end
            // unused codes above the last branch must stay without effect
            if (op_code >= bscu_pkg::BSCU_FLAG_SET_BRANCH
                && op_code <= bscu_pkg::BSCU_OVERFLOW_SET_BRANCH)
            begin
                next_pc_load    = 1'b1;
                next_pc_out     = take ? target : fall;
                next_cycle_cost = take ? bscu_pkg::CYC_TAKEN : bscu_pkg::CYC_BASE;
            end
            if (next_cycle_cost > bscu_pkg::CYC_BASE)
            begin
                next_state      = BSCU_WAIT;
                next_wait_count = next_cycle_cost - 3'h1;
            end
        end
    end

    // registers only; flags and pc outputs come straight from flip-flops
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state                 <= BSCU_IDLE;
            wait_count            <= 3'h0;
            pc_out                <= bscu_pkg::PC_RESET;
            pc_load               <= 1'b0;
            status_flags_register <= bscu_pkg::FLAGS_RESET;
            flags_write           <= 1'b0;
            push_data             <= bscu_pkg::PC_RESET;
            push_strobe           <= 1'b0;
            pop_strobe            <= 1'b0;
            cycle_cost            <= 3'h0;
        end
        else
        begin
            state                 <= next_state;
            wait_count            <= next_wait_count;
            pc_out                <= next_pc_out;
            pc_load               <= next_pc_load;
            status_flags_register <= next_flags;
            flags_write           <= next_flags_write;
            push_data             <= next_push_data;
            push_strobe           <= next_push_strobe;
            pop_strobe            <= next_pop_strobe;
            cycle_cost            <= next_cycle_cost;
        end
    end

    // ready is combinational so the decoder can stall in the same cycle
    always_comb
    begin
        op_ready = (state == BSCU_IDLE);
        busy     = (state == BSCU_WAIT);
    end

endmodule

`default_nettype wire

// ---- bscu_pkg.sv ----
package bscu_pkg;

    // operation selector presented by the decoder; one code per control-flow operation
    typedef enum logic [4:0]
    {
        BSCU_OP_NONE,
        BSCU_INDIRECT_CALL,
        BSCU_SUBROUTINE_EXIT,
        BSCU_INTERRUPT_EXIT,
        BSCU_EQUAL_SKIP,
        BSCU_REGISTER_COMPARE,
        BSCU_CARRY_COMPARE,
        BSCU_IMMEDIATE_COMPARE,
        BSCU_SKIP_REG_BIT_CLEAR,
        BSCU_SKIP_REG_BIT_SET,
        BSCU_SKIP_IO_BIT_CLEAR,
        BSCU_SKIP_IO_BIT_SET,
        BSCU_FLAG_SET_BRANCH,
        BSCU_FLAG_CLEAR_BRANCH,
        BSCU_EQUAL_BRANCH,
        BSCU_UNEQUAL_BRANCH,
        BSCU_CARRY_SET_BRANCH,
        BSCU_CARRY_CLEAR_BRANCH,
        BSCU_SAME_HIGHER_BRANCH,
        BSCU_LOWER_BRANCH,
        BSCU_MINUS_BRANCH,
        BSCU_PLUS_BRANCH,
        BSCU_SIGNED_GE_BRANCH,
        BSCU_SIGNED_LESS_BRANCH,
        BSCU_HALF_CARRY_SET_BRANCH,
        BSCU_HALF_CARRY_CLEAR_BRANCH,
        BSCU_XFER_FLAG_SET_BRANCH,
        BSCU_XFER_FLAG_CLEAR_BRANCH,
        BSCU_OVERFLOW_SET_BRANCH
    } bscu_op_t;

    // status flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // cycle costs
    localparam logic [2:0] CYC_BASE     = 3'h1;
    localparam logic [2:0] CYC_TAKEN    = 3'h2;
    localparam logic [2:0] CYC_SKIP1    = 3'h2;
    localparam logic [2:0] CYC_SKIP2    = 3'h3;
    localparam logic [2:0] CYC_CALL     = 3'h3;
    localparam logic [2:0] CYC_RETURN   = 3'h4;

    // reset values
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

endpackage

// ---- bscu_compare.sv ----
`timescale 1ns/1ps
`default_nettype none

// 8-bit subtract used only for flag results; the difference is never stored
module bscu_compare
(
    input  wire logic [7:0] lhs,
    input  wire logic [7:0] rhs,
    input  wire logic       borrow_in,
    input  wire logic       chain_zero,
    input  wire logic       old_zero,
    output logic      [5:0] flags_out
);
    logic [7:0] diff;
    logic       c;
    logic       z;
    logic       n;
    logic       v;
    logic       h;

    // flags_out = {h, s, v, n, z, c}; chained compare keeps zero only if already zero
    always_comb
    begin
        diff = lhs - rhs - {7'h00, borrow_in};
        c = (~lhs[7] & rhs[7]) | (rhs[7] & diff[7]) | (diff[7] & ~lhs[7]);
        h = (~lhs[3] & rhs[3]) | (rhs[3] & diff[3]) | (diff[3] & ~lhs[3]);
        v = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
        n = diff[7];
        z = (diff == 8'h00) & (~chain_zero | old_zero);
        flags_out = {h, n ^ v, v, n, z, c};
    end

endmodule

`default_nettype wire

// ---- bscu_unit_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module bscu_unit_checker
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               op_valid,
    input wire bscu_pkg::bscu_op_t op_code,
    input wire logic [15:0]        op_pc,
    input wire logic [7:0]         src_a,
    input wire logic [7:0]         src_b,
    input wire logic [6:0]         branch_offset,
    input wire logic [15:0]        pointer_z,
    input wire logic               next_is_two_word,
    input wire logic [15:0]        stack_pop_data,
    input wire logic [7:0]         status_flags_in,
    input wire logic               op_ready,
    input wire logic               busy,
    input wire logic [15:0]        pc_out,
    input wire logic               pc_load,
    input wire logic [7:0]         status_flags_register,
    input wire logic               flags_write,
    input wire logic [15:0]        push_data,
    input wire logic               push_strobe,
    input wire logic               pop_strobe,
    input wire logic [2:0]         cycle_cost
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // accepted request and the relative target it would reach
    logic        take;
    logic [15:0] target;
    logic        ret;
    assign take   = op_valid && op_ready;
    assign target = op_pc + {{9{branch_offset[6]}}, branch_offset} + 16'h0001;
    assign ret    = op_code inside {bscu_pkg::BSCU_SUBROUTINE_EXIT, bscu_pkg::BSCU_INTERRUPT_EXIT};
    chk_call_target: assert property (
        take && op_code == bscu_pkg::BSCU_INDIRECT_CALL |=> push_strobe && pc_load && !flags_write
        && pc_out == $past(pointer_z) && push_data == $past(op_pc) + 16'h0001 && cycle_cost == 3'h3)
        else $error("indirect call result wrong");
    chk_call_busy: assert property (
        take && op_code == bscu_pkg::BSCU_INDIRECT_CALL |=> busy [*2] ##1 op_ready)
        else $error("indirect call busy span wrong");
    chk_return_pop: assert property (
        take && ret |=> pop_strobe && pc_load && pc_out == $past(stack_pop_data) && cycle_cost == 3'h4)
        else $error("return result wrong");
    chk_return_busy: assert property (take && ret |=> busy [*3] ##1 op_ready)
        else $error("return busy span wrong");
    chk_irq_enable: assert property (
        take && op_code == bscu_pkg::BSCU_INTERRUPT_EXIT |=> flags_write && status_flags_register[7])
        else $error("interrupt exit enable wrong");
    chk_branch_target: assert property (
        take && op_code >= bscu_pkg::BSCU_FLAG_SET_BRANCH |=> pc_load && !flags_write
        && (cycle_cost == 3'h2 ? pc_out == $past(target)
        : cycle_cost == 3'h1 && pc_out == $past(op_pc) + 16'h0001))
        else $error("branch target wrong");
    chk_equal_branch: assert property (
        take && op_code == bscu_pkg::BSCU_EQUAL_BRANCH
        |=> cycle_cost == ($past(status_flags_in[1]) ? 3'h2 : 3'h1))
        else $error("equal branch cost wrong");
    chk_compare_low: assert property (
        take && op_code == bscu_pkg::BSCU_REGISTER_COMPARE |=> flags_write && cycle_cost == 3'h1
        && status_flags_register[1:0] == {$past(src_a == src_b), $past(src_a < src_b)})
        else $error("compare zero or carry wrong");
    chk_skip_equal: assert property (
        take && op_code == bscu_pkg::BSCU_EQUAL_SKIP |=> !flags_write
        && cycle_cost == ($past(src_a == src_b) ? ($past(next_is_two_word) ? 3'h3 : 3'h2) : 3'h1)
        && pc_out == $past(op_pc) + {13'h0000, cycle_cost})
        else $error("equal skip wrong");
    cover property (take && op_code == bscu_pkg::BSCU_INTERRUPT_EXIT);
    cover property (take && op_code == bscu_pkg::BSCU_EQUAL_SKIP && next_is_two_word);
    cover property (pc_load && cycle_cost == 3'h2);
endmodule
bind bscu_unit bscu_unit_checker bscu_unit_checker_inst
(
    .clk, .sys_rst, .op_valid, .op_code, .op_pc, .src_a, .src_b, .branch_offset, .pointer_z,
    .next_is_two_word, .stack_pop_data, .status_flags_in, .op_ready, .busy, .pc_out, .pc_load,
    .status_flags_register, .flags_write, .push_data, .push_strobe, .pop_strobe, .cycle_cost
);
`default_nettype wire

// ---- tb_branch_skip_compare_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_branch_skip_compare_unit;
    logic               clk, sys_rst, op_valid, next_is_two_word, op_ready, busy;
    logic               pc_load, flags_write, push_strobe, pop_strobe;
    bscu_pkg::bscu_op_t op_code;
    logic [15:0]        op_pc, pointer_z, stack_pop_data, pc_out, push_data;
    logic [7:0]         src_a, src_b, imm_value, io_read_data, status_flags_in;
    logic [7:0]         status_flags_register;
    logic [6:0]         branch_offset;
    logic [2:0]         bit_index, cycle_cost;
    int                 n_mismatch, check_count;
    bscu_unit bscu_unit_inst
    (
        .clk, .sys_rst, .op_valid, .op_code, .op_pc, .src_a, .src_b, .imm_value, .bit_index,
        .branch_offset, .pointer_z, .io_read_data, .next_is_two_word, .stack_pop_data,
        .status_flags_in, .op_ready, .busy, .pc_out, .pc_load, .status_flags_register,
        .flags_write, .push_data, .push_strobe, .pop_strobe, .cycle_cost
    );
    always #12.5 clk = ~clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one request; op_pc, branch_offset, pointer_z and stack_pop_data move every call so stale values cannot match
    task automatic run(input int i, input logic [7:0] a, b, f, input logic [2:0] s, input logic tw);
        int k;
        k = 0;
        while (op_ready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 20)
        begin
            n_mismatch++;
            test_done();
        end
        @(posedge clk);
        op_valid         <= 1'b1;
        op_code          <= bscu_pkg::bscu_op_t'(i);
        src_a            <= a;
        io_read_data     <= a;
        imm_value        <= b;
        src_b            <= (i == 7) ? ~b : b;
        status_flags_in  <= f;
        bit_index        <= s;
        next_is_two_word <= tw;
        op_pc            <= op_pc + 16'h0101;
        branch_offset    <= ~branch_offset;
        pointer_z        <= op_pc ^ 16'h5A5A;
        stack_pop_data   <= op_pc ^ 16'hC3C3;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    // expected compare flags {I,T,H,S,V,N,Z,C}
    function automatic logic [7:0] cmp_exp(input logic [7:0] a, b, f, input logic cc);
        logic [8:0] d;
        logic       c, n, v;
        c = cc & f[0];
        d = {1'b0, a} - {1'b0, b} - {8'h00, c};
        n = d[7];
        v = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
        return {f[7:6], {1'b0, a[3:0]} < {1'b0, b[3:0]} + {4'h0, c}, n ^ v, v, n,
                d[7:0] == 8'h00 && (!cc || f[1]), d[8]};
    endfunction
    // branch condition by operation code, in enum order
    function automatic logic br_exp(input int i, input logic [7:0] f, input logic [2:0] s);
        case (i)
            12: return f[s];
            13: return !f[s];
            14: return f[1];
            15: return !f[1];
            16, 19: return f[0];
            17, 18: return !f[0];
            20: return f[2];
            21: return !f[2];
            22: return !(f[2] ^ f[3]);
            23: return f[2] ^ f[3];
            24: return f[5];
            25: return !f[5];
            26: return f[6];
            27: return !f[6];
            default: return f[3];
        endcase
    endfunction
    task automatic t_call;
        run(1, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
        chk("call target", pointer_z, pc_out);
        chk("call push", op_pc + 16'h0001, push_data);
        chk("call strobes", 16'h0005, {push_strobe, flags_write, pc_load});
        chk("call cost", 16'h0003, {13'h0000, cycle_cost});
        // a request while busy must be ignored
        @(posedge clk);
        op_valid <= 1'b1;
        op_code  <= bscu_pkg::BSCU_REGISTER_COMPARE;
        #1;
        chk("call busy", 16'h0001, {15'h0000, busy});
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("refused write", 16'h0000, {15'h0000, flags_write});
        $display("call test done");
    endtask
    task automatic t_return;
        run(2, 8'h00, 8'h00, 8'h3C, 3'h0, 1'b0);
        chk("return target", stack_pop_data, pc_out);
        chk("return strobes", 16'h0003, {flags_write, pop_strobe, pc_load});
        chk("return cost", 16'h0004, {13'h0000, cycle_cost});
        run(3, 8'h00, 8'h00, 8'h3C, 3'h0, 1'b0);
        chk("irq return flags", 16'h00BC, {8'h00, status_flags_register});
        chk("irq return pop", 16'h0003, {flags_write, pop_strobe});
        $display("return test done");
    endtask
    task automatic t_compare;
        logic [7:0] va[5] = '{8'h80, 8'h10, 8'h05, 8'h00, 8'hFF};
        logic [7:0] vb[5] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h7F};
        for (int k = 0; k < 10; k++)
            for (int i = 5; i < 8; i++)
            begin
                run(i, va[k / 2], vb[k / 2], k[0] ? 8'h43 : 8'h80, 3'h0, 1'b0);
                chk("compare flags", cmp_exp(va[k / 2], vb[k / 2], status_flags_in, i == 6),
                    status_flags_register);
                chk("compare write", 16'h0009, {12'h000, flags_write, cycle_cost});
            end
        $display("compare test done");
    endtask
    task automatic t_skip;
        logic hit;
        for (int i = 4; i < 12; i++)
            for (int s = 0; s < 8; s++)
            begin
                if (i == 4 || i > 7)
                begin
                    run(i, 8'h5A, s[1] ? 8'h5A : 8'h5B, 8'hFF, 3'(s), s[0]);
                    hit = (i == 4) ? s[1] : ((i == 8 || i == 10) ? !src_a[s] : src_a[s]);
                    chk("skip cost", hit ? (s[0] ? 16'h0003 : 16'h0002) : 16'h0001,
                        {13'h0000, cycle_cost});
                    chk("skip pc", op_pc + (hit ? (s[0] ? 16'h0003 : 16'h0002) : 16'h0001),
                        pc_out);
                    chk("skip flags", 16'h0000, {15'h0000, flags_write});
                end
            end
        $display("skip test done");
    endtask
    task automatic t_branch;
        logic [7:0] fp[4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
        logic       hit;
        for (int i = 12; i < 29; i++)
            for (int p = 0; p < 8; p++)
            begin
                run(i, 8'h00, 8'h00, fp[p % 4], 3'(p + i), 1'b0);
                hit = br_exp(i, fp[p % 4], bit_index);
                chk("branch cost", hit ? 16'h0002 : 16'h0001,
                    {13'h0000, cycle_cost});
                chk("branch pc", op_pc + 16'h0001 + (hit ? {{9{branch_offset[6]}},
                    branch_offset} : 16'h0000), pc_out);
                chk("branch flags", 16'h0000, {15'h0000, flags_write});
            end
        $display("branch test done");
    endtask
    // reset while a return is still counting; the unit must come back idle and usable
    task automatic t_reset;
        run(2, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b1;
        #1;
        chk("reset mid state", 16'h0002, {14'h0000, op_ready, busy});
        chk("reset mid pc", 16'h0000, pc_out);
        chk("reset mid flags", 16'h0000, {8'h00, status_flags_register});
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        run(0, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
        chk("no-op effect", 16'h0001, {pc_load, flags_write, push_strobe, pop_strobe, 9'h000,
            cycle_cost});
        run(5, 8'h10, 8'h01, 8'h01, 3'h0, 1'b0);
        chk("compare after reset", cmp_exp(8'h10, 8'h01, 8'h01, 1'b0),
            status_flags_register);
        $display("reset test done");
    endtask
    initial
    begin
        {clk, op_valid, next_is_two_word, op_pc, pointer_z, stack_pop_data} = '0;
        {src_a, src_b, imm_value, io_read_data, status_flags_in, bit_index} = '0;
        sys_rst       = 1'b1;
        op_code       = bscu_pkg::BSCU_OP_NONE;
        branch_offset = 7'h40;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("reset state", 16'h0002, {14'h0000, op_ready, busy});
        t_call();
        t_return();
        t_compare();
        t_skip();
        t_branch();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
